// File: design/ssw_defines.svh
// ssw_defines.svh: offsets-free constants of the supply supervisor watchdog reset block.
// assumes a single 125 MHz system clock; times are kept in their own units and cycle counts derive from them.
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

// system clock period in picoseconds (125 MHz)
`define SSW_CLK_PERIOD_PS     8000
// system clock cycles per millisecond
`define SSW_CLK_PER_MS        125000

// watchdog strobe timeout, typical, in milliseconds
`define SSW_STROBE_TIMEOUT_MS 1600
// reset hold period after a cause ends, minimum, in milliseconds
`define SSW_RESET_HOLD_MS     140
// manual reset glitch rejection width, typical, in nanoseconds
`define SSW_MR_GLITCH_NS      100
// manual reset minimum pulse width that must reset, in nanoseconds
`define SSW_MR_MIN_PULSE_NS   1000
// least strobe pulse width that must count as a transition, in nanoseconds
`define SSW_STROBE_PULSE_NS   50
// supply dip duration that is still rejected, in nanoseconds
`define SSW_UV_GLITCH_NS      8000

// derived cycle counts; glitch widths round up so a full-width glitch is always covered
`define SSW_MR_GLITCH_CYC     ((`SSW_MR_GLITCH_NS * 1000 + `SSW_CLK_PERIOD_PS - 1) / `SSW_CLK_PERIOD_PS)
`define SSW_UV_GLITCH_CYC     ((`SSW_UV_GLITCH_NS * 1000 + `SSW_CLK_PERIOD_PS - 1) / `SSW_CLK_PERIOD_PS)
`define SSW_STROBE_TIMEOUT_CYC (`SSW_STROBE_TIMEOUT_MS * `SSW_CLK_PER_MS)
`define SSW_RESET_HOLD_CYC    (`SSW_RESET_HOLD_MS * `SSW_CLK_PER_MS)

// pin vector layout inside the synchroniser
`define SSW_PIN_MR_N          0
`define SSW_PIN_MR_FLOAT      1
`define SSW_PIN_STROBE        2
`define SSW_PIN_STROBE_FLOAT  3
`define SSW_PIN_UV            4
`define SSW_PIN_COUNT         5
// reset values of the synchronised pins: button released, pins driven, strobe low, supply low
`define SSW_PIN_RESET_VAL     5'h11

// counter width for the long timers (200,000,000 cycles fit in 28 bits)
`define SSW_CNT_W             28
// counter width for the short glitch filters
`define SSW_FILT_W            16

`endif

// File: design/ssw_glitch_filter.sv
// ssw_glitch_filter: passes a level change only after it has stood for more than CYC samples.
// assumes a synchronised input; each direction can be filtered or passed straight through.
`timescale 1ns/100ps
`include "ssw_defines.svh"

module ssw_glitch_filter
  import ssw_pkg::*;
#(
  parameter int unsigned CYC         = 1,
  parameter logic        RESET_VAL   = 1'b0,
  parameter logic        FILTER_RISE = 1'b1,
  parameter logic        FILTER_FALL = 1'b1
) (
  // clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  // synchronised level in, filtered level out
  input  wire logic level_in,
  output logic      level_out
);

  ssw_filt_t run_cnt;
  logic      filtered_dir;

  // a rise is filtered when FILTER_RISE, a fall when FILTER_FALL
  assign filtered_dir = level_in ? FILTER_RISE : FILTER_FALL;

  // the counter restarts whenever the input returns to the output level,
  // so a glitch never accumulates across separate short pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_cnt   <= '0;
      level_out <= RESET_VAL;
    end else if (clk_en) begin
      if (level_in == level_out) begin
        run_cnt <= '0;
      end else if (!filtered_dir || run_cnt == ssw_filt_t'(CYC)) begin
        run_cnt   <= '0;
        level_out <= level_in;
      end else begin
        run_cnt <= run_cnt + 1'b1;
      end
    end
  end

endmodule

// File: design/ssw_pin_sync.sv
// ssw_pin_sync: three-flop synchroniser for asynchronous pad inputs, with agreement check and change pulse.
// assumes clk_sys is free running; pins may change at any time.
`timescale 1ns/100ps
`include "ssw_defines.svh"

module ssw_pin_sync
  import ssw_pkg::*;
#(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock, reset, enable
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // asynchronous pins
  input  wire logic [W-1:0] pin_in,
  // synchronised level and one-cycle change pulse
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] change_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // stage1 feeds stage2 only; the level moves once stage2 and stage3 agree
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          stage1[g]     <= RESET_VAL[g];
          stage2[g]     <= RESET_VAL[g];
          stage3[g]     <= RESET_VAL[g];
          level_out[g]  <= RESET_VAL[g];
          change_out[g] <= 1'b0;
        end else if (clk_en) begin
          stage1[g]     <= pin_in[g];
          stage2[g]     <= stage1[g];
          stage3[g]     <= stage2[g];
          change_out[g] <= (stage2[g] == stage3[g]) && (stage3[g] != level_out[g]);
          if (stage2[g] == stage3[g]) begin
            level_out[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule

// File: design/ssw_pkg.sv
// ssw_pkg: types shared by the supply supervisor watchdog reset block.
// assumes ssw_defines.svh is on the include path.
`include "ssw_defines.svh"

package ssw_pkg;

  // reset sequencer states, gray coded along cause -> hold -> run -> hold
  typedef enum logic [1:0] {
    SSW_ST_CAUSE = 2'h0,
    SSW_ST_HOLD  = 2'h1,
    SSW_ST_RUN   = 2'h3
  } ssw_state_e;

  typedef logic [`SSW_CNT_W-1:0]     ssw_cnt_t;
  typedef logic [`SSW_FILT_W-1:0]    ssw_filt_t;
  typedef logic [`SSW_PIN_COUNT-1:0] ssw_pinvec_t;

  // pin-side inputs; the float flags come from the pad window comparators
  typedef struct packed {
    logic undervoltage;
    logic strobe_float;
    logic watchdog_strobe_in;
    logic mr_float;
    logic manual_reset_in_n;
  } ssw_pins_s;

  // reset outputs toward the processor
  typedef struct packed {
    logic reset_out_n;
    logic reset_out;
  } ssw_reset_s;

endpackage

// File: design/ssw_supervisor.sv
// ssw_supervisor: reset generator with supply monitor input, manual reset and watchdog strobe timer.
// assumes the undervoltage level comes from an analog comparator against supply_threshold and that
// the pad window comparators flag a floating manual reset or strobe pin; all pins are asynchronous.
//
// How it works
// - reset on undervoltage, manual reset, or watchdog expiry
// - hold reset full period after each cause ends
// - active-low output plus optional complementary high output
// - low manual reset input asserts reset after 14 agreeing filter samples
// - unconnected manual reset input reads as high
// - manual reset input debounced on chip
// - manual reset glitches up to 100 ns ignored
// - every strobe edge, either direction, clears watchdog
// - strobe pulses of 50 ns still clear watchdog
// - full timeout without strobe edge asserts reset
// - undervoltage or manual reset also clears watchdog
// - watchdog held clear while reset is asserted
// - floating strobe input disconnects the watchdog
// - short shallow supply dips are rejected
// - manual reset low 1 us always resets
`timescale 1ns/100ps
`include "ssw_defines.svh"

module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int unsigned STROBE_TIMEOUT_CYC = `SSW_STROBE_TIMEOUT_CYC,
  parameter int unsigned RESET_HOLD_CYC     = `SSW_RESET_HOLD_CYC,
  parameter logic        COMPLEMENT_EN      = 1'b1
) (
  // clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // pad-side inputs
  input  wire ssw_pins_s  pins_in,
  // reset outputs toward the processor
  output ssw_reset_s      reset_out,
  // observation of the internal causes
  output logic            wdog_expired_out,
  output logic            cause_active_out
);

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------

  ssw_pinvec_t pin_vec;
  ssw_pinvec_t pin_level;
  ssw_pinvec_t pin_change;

  // gather pins into one vector so one synchroniser handles them all
  always_comb begin
    pin_vec                        = '0;
    pin_vec[`SSW_PIN_MR_N]         = pins_in.manual_reset_in_n;
    pin_vec[`SSW_PIN_MR_FLOAT]     = pins_in.mr_float;
    pin_vec[`SSW_PIN_STROBE]       = pins_in.watchdog_strobe_in;
    pin_vec[`SSW_PIN_STROBE_FLOAT] = pins_in.strobe_float;
    pin_vec[`SSW_PIN_UV]           = pins_in.undervoltage;
  end

  // every pad input passes three flops before anything looks at it
  ssw_pin_sync #(
    .W         (`SSW_PIN_COUNT),
    .RESET_VAL (ssw_pinvec_t'(`SSW_PIN_RESET_VAL))
  ) u_sync (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .clk_en     (clk_en),
    .pin_in     (pin_vec),
    .level_out  (pin_level),
    .change_out (pin_change)
  );

  // ------------------------------------------------------------------
  // manual reset path
  // ------------------------------------------------------------------

  logic mr_level_n;
  logic mr_clean_n;
  logic mr_active;

  // a floating pin reads high through the internal pull-up
  assign mr_level_n = pin_level[`SSW_PIN_MR_N] | pin_level[`SSW_PIN_MR_FLOAT];

  // symmetric filter: 14 agreeing samples (112 ns) before a change is taken,
  // which swallows 100 ns glitches and button bounce yet stays well inside 1 us
  ssw_glitch_filter #(
    .CYC         (`SSW_MR_GLITCH_CYC),
    .RESET_VAL   (1'b1),
    .FILTER_RISE (1'b1),
    .FILTER_FALL (1'b1)
  ) u_mr_filter (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .level_in  (mr_level_n),
    .level_out (mr_clean_n)
  );

  assign mr_active = ~mr_clean_n;

  // ------------------------------------------------------------------
  // supply monitor path
  // ------------------------------------------------------------------

  logic uv_active;

  // only the falling supply is filtered; recovery is taken at once, since
  // the hold period already covers supply stabilisation. depth is analog
  // and not seen here, so only dip duration is judged.
  ssw_glitch_filter #(
    .CYC         (`SSW_UV_GLITCH_CYC),
    .RESET_VAL   (1'b1),
    .FILTER_RISE (1'b1),
    .FILTER_FALL (1'b0)
  ) u_uv_filter (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .level_in  (pin_level[`SSW_PIN_UV]),
    .level_out (uv_active)
  );

  // ------------------------------------------------------------------
  // cause combination and sequencer
  // ------------------------------------------------------------------

  ssw_state_e state;
  ssw_state_e next_state;
  ssw_cnt_t   hold_cnt;
  ssw_cnt_t   wdog_cnt;
  logic       cause_level;
  logic       hold_done;
  logic       wdog_enabled;
  logic       strobe_edge;
  logic       wdog_fire;

  assign cause_level = uv_active | mr_active;
  assign hold_done   = (hold_cnt == ssw_cnt_t'(RESET_HOLD_CYC - 1));

  // a strobe edge counts only while the pin is driven
  assign wdog_enabled = ~pin_level[`SSW_PIN_STROBE_FLOAT];
  assign strobe_edge  = pin_change[`SSW_PIN_STROBE] & wdog_enabled;

  // expiry is the last count of a full timeout with no edge in that cycle
  assign wdog_fire = (state == SSW_ST_RUN) && wdog_enabled && !strobe_edge &&
                     (wdog_cnt == ssw_cnt_t'(STROBE_TIMEOUT_CYC - 1));

  // next-state decode: a level cause always wins, then expiry, then the hold
  always_comb begin
    next_state = state;
    case (state)
      SSW_ST_CAUSE: begin
        if (!cause_level) begin
          next_state = SSW_ST_HOLD;
        end
      end
      SSW_ST_HOLD: begin
        if (cause_level) begin
          next_state = SSW_ST_CAUSE;
        end else if (hold_done) begin
          next_state = SSW_ST_RUN;
        end
      end
      SSW_ST_RUN: begin
        if (cause_level) begin
          next_state = SSW_ST_CAUSE;
        end else if (wdog_fire) begin
          next_state = SSW_ST_HOLD;
        end
      end
      default: begin
        next_state = SSW_ST_CAUSE;
      end
    endcase
  end

  // sequencer state; power-up starts as if a cause had just been seen
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= SSW_ST_CAUSE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // hold timer counts only in the hold state and restarts on every entry,
  // so a cause that reappears mid-hold always buys a fresh full period
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_cnt <= '0;
    end else if (clk_en) begin
      if (state == SSW_ST_HOLD && next_state == SSW_ST_HOLD) begin
        hold_cnt <= hold_cnt + 1'b1;
      end else begin
        hold_cnt <= '0;
      end
    end
  end

  // ------------------------------------------------------------------
  // watchdog timer
  // ------------------------------------------------------------------

  // counts only while reset is released and the strobe pin is driven;
  // any reset, any strobe edge or a float clears it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdog_cnt <= '0;
    end else if (clk_en) begin
      if (state != SSW_ST_RUN || cause_level) begin
        wdog_cnt <= '0;
      end else if (!wdog_enabled) begin
        wdog_cnt <= '0;
      end else if (strobe_edge || wdog_fire) begin
        wdog_cnt <= '0;
      end else begin
        wdog_cnt <= wdog_cnt + 1'b1;
      end
    end
  end

  // one-cycle expiry flag for observation
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdog_expired_out <= 1'b0;
    end else if (clk_en) begin
      wdog_expired_out <= wdog_fire && !cause_level;
    end
  end

  // ------------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------------

  // both polarities come from one flop pair driven by the same state,
  // so they never disagree; the high output is tied low when not fitted
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reset_out.reset_out_n <= 1'b0;
      reset_out.reset_out   <= COMPLEMENT_EN;
      cause_active_out      <= 1'b0;
    end else if (clk_en) begin
      reset_out.reset_out_n <= (next_state == SSW_ST_RUN);
      reset_out.reset_out   <= COMPLEMENT_EN & (next_state != SSW_ST_RUN);
      cause_active_out      <= cause_level;
    end
  end

endmodule

// File: testbench/ssw_cpu_model.sv
// ssw_cpu_model: processor side, held in reset by the supervisor and strobing its watchdog.
// assumes period and pulse are set by the bench; a released pin wanders every cycle.
`timescale 1ns/100ps
module ssw_cpu_model (
  // clock and controls
  input  wire logic        clk_sys,
  input  wire logic        reset_in_n,
  input  wire logic        service_en,
  input  wire logic        release_pin,
  input  wire logic [15:0] period,
  input  wire logic [15:0] pulse,
  // strobe pin
  output logic             strobe
);
  logic [15:0] tick;
  // a high pulse of pulse cycles opens each period; the line is low for the rest
  always_ff @(posedge clk_sys) begin
    if (release_pin) begin
      strobe <= !strobe;  // no pull on this pin, so a stale level would hide faults
      tick   <= '0;
    end else if (!reset_in_n || !service_en) begin
      strobe <= 1'b0;
      tick   <= '0;
    end else begin
      // wrap on or past the end, so a shorter period set mid-count never stalls the strobe
      tick   <= (tick >= period - 1) ? '0 : tick + 1;
      strobe <= (tick < pulse);
    end
  end
endmodule

// File: testbench/ssw_supervisor_assertions.sv
// ssw_chk: port-level timing checks on the reset generator.
// assumes clk_en held high and the bind below reaching every supervisor.
`timescale 1ns/100ps
module ssw_chk
  import ssw_pkg::*;
#(
  parameter int unsigned STROBE_TIMEOUT_CYC = 200,
  parameter int unsigned RESET_HOLD_CYC     = 50,
  parameter logic        COMPLEMENT_EN      = 1'b1
) (
  // clock, reset, enable
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       clk_en,
  // watched ports
  input wire ssw_pins_s  pins_in,
  input wire ssw_reset_s reset_out,
  input wire logic       wdog_expired_out,
  input wire logic       cause_active_out
);
  logic [31:0] hold;
  logic [31:0] run;
  logic [31:0] mr_low;
  logic        strobe_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // run counts released cycles since the last strobe pin edge; pin-side, so it leads the design
  always_ff @(posedge clk_sys) begin
    strobe_d <= pins_in.watchdog_strobe_in;
    run      <= (reset || !reset_out.reset_out_n || pins_in.strobe_float ||
                 strobe_d != pins_in.watchdog_strobe_in) ? '0 : run + 1;
  end
  // hold counts cause-free reset cycles; mr_low counts a held button
  always_ff @(posedge clk_sys) begin
    hold   <= (reset || cause_active_out || reset_out.reset_out_n) ? '0 : hold + 1;
    mr_low <= (pins_in.manual_reset_in_n || pins_in.mr_float) ? '0 : mr_low + 1;
  end
  compl_out_a: assert property (COMPLEMENT_EN |-> reset_out.reset_out == !reset_out.reset_out_n)
    else $error("reset outputs not complementary");
  cause_rst_a: assert property (cause_active_out |=> !reset_out.reset_out_n)
    else $error("cause present without reset");
  wdog_rst_a: assert property (wdog_expired_out |-> !reset_out.reset_out_n)
    else $error("expiry without reset");
  hold_min_a: assert property ($rose(reset_out.reset_out_n) |-> hold >= RESET_HOLD_CYC - 2)
    else $error("reset released before hold ran out");
  hold_max_a: assert property (hold <= RESET_HOLD_CYC + 12)
    else $error("reset held too long");
  wdog_early_a: assert property (wdog_expired_out |-> run >= STROBE_TIMEOUT_CYC - 3)
    else $error("watchdog expired early");
  wdog_late_a: assert property (run <= STROBE_TIMEOUT_CYC + 8)
    else $error("watchdog missed its timeout");
  float_off_a: assert property (pins_in.strobe_float [*8] |-> !wdog_expired_out)
    else $error("floating strobe still expired");
  mr_fast_a: assert property (mr_low == 30 |-> !reset_out.reset_out_n)
    else $error("held button gave no reset");
endmodule

bind ssw_supervisor ssw_chk #(
  .STROBE_TIMEOUT_CYC (STROBE_TIMEOUT_CYC),
  .RESET_HOLD_CYC     (RESET_HOLD_CYC),
  .COMPLEMENT_EN      (COMPLEMENT_EN)
) u_chk (
  .clk_sys          (clk_sys),
  .reset            (reset),
  .clk_en           (clk_en),
  .pins_in          (pins_in),
  .reset_out        (reset_out),
  .wdog_expired_out (wdog_expired_out),
  .cause_active_out (cause_active_out)
);

// File: testbench/tb_supply_supervisor_watchdog_reset.sv
// tb_supply_supervisor_watchdog_reset: directed tests of the reset generator with a processor model.
// assumes shortened timer parameters so the whole run stays within a few thousand cycles.
`timescale 1ns/100ps
module tb_supply_supervisor_watchdog_reset
  import ssw_pkg::*;
();
  localparam int TOUT = 200;
  localparam int HOLD = 50;
  logic        clk_sys;
  logic        reset;
  logic        mr_n, mr_fl, st_fl, uv, strobe, svc, wdog_exp, cause;
  logic [15:0] period;
  logic [15:0] pulse;
  ssw_pins_s   pins;
  ssw_reset_s  rst_o;
  int          errors, n_compared, cycles, n, m;

  assign pins = {uv, st_fl, strobe, mr_fl, mr_n};

  ssw_supervisor #(.STROBE_TIMEOUT_CYC(TOUT), .RESET_HOLD_CYC(HOLD), .COMPLEMENT_EN(1'b1)) uut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .pins_in(pins), .reset_out(rst_o),
    .wdog_expired_out(wdog_exp), .cause_active_out(cause));

  ssw_cpu_model u_cpu (.clk_sys(clk_sys), .reset_in_n(rst_o.reset_out_n), .service_en(svc),
    .release_pin(st_fl), .period(period), .pulse(pulse), .strobe(strobe));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // counts falling edges until the low-active reset reaches lvl, at most lim
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (rst_o.reset_out_n !== lvl && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // supply comes good, then the unserviced watchdog fires twice
  task automatic t_power_wdog;
    @(posedge clk_sys) uv <= 1'b0;
    wait_rst(1'b1, 200, n);
    check("power-up hold", n >= HOLD && n <= HOLD + 12, 1);
    for (int i = 0; i < 2; i++) begin
      wait_rst(1'b0, TOUT + 20, n);
      check("watchdog timeout", n >= TOUT - 3 && n <= TOUT + 3, 1);
      check("high reset output", rst_o.reset_out, 1);
      check("expiry pulse", wdog_exp, 1);
      wait_rst(1'b1, HOLD + 20, n);
      check("expiry hold", n >= HOLD && n <= HOLD + 3, 1);
    end
    $display("power and watchdog test done");
  endtask

  // both edges must count, and a 56 ns pulse must be seen
  task automatic t_strobe;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      svc    <= 1'b1;
      period <= i ? 16'h0096 : 16'h012C;
      pulse  <= i ? 16'h0007 : 16'h0096;
      wait_rst(1'b0, 800, n);
      check("serviced watchdog", n, 800);
    end
    @(posedge clk_sys) st_fl <= 1'b1;
    wait_rst(1'b0, 3 * TOUT, n);
    check("floating strobe", n, 3 * TOUT);
    @(posedge clk_sys) st_fl <= 1'b0;
    $display("strobe test done");
  endtask

  // button glitch, floating pin, then a full press
  task automatic t_manual;
    @(posedge clk_sys) mr_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    mr_n  <= 1'b1;
    mr_fl <= 1'b1;
    wait_rst(1'b0, 60, n);
    check("button glitch", n, 60);
    @(posedge clk_sys);
    mr_fl <= 1'b0;
    mr_n  <= 1'b0;
    wait_rst(1'b0, 30, n);
    check("button reset", n < 30, 1);
    repeat (125 - n) @(posedge clk_sys);
    mr_n <= 1'b1;
    wait_rst(1'b1, HOLD + 40, n);
    check("button hold", n >= HOLD + 13 && n <= HOLD + 30, 1);
    $display("manual reset test done");
  endtask

  // a short dip is ignored, a longer one resets
  task automatic t_supply;
    @(posedge clk_sys) uv <= 1'b1;
    wait_rst(1'b0, 990, n);
    @(posedge clk_sys) uv <= 1'b0;
    wait_rst(1'b0, 20, m);
    check("short dip", n + m, 1010);
    @(posedge clk_sys) uv <= 1'b1;
    wait_rst(1'b0, 1100, n);
    check("long dip", n >= 1000 && n <= 1012, 1);
    check("supply cause", cause, 1);
    @(posedge clk_sys) uv <= 1'b0;
    wait_rst(1'b1, HOLD + 20, n);
    check("supply hold", n >= HOLD && n <= HOLD + 12, 1);
    $display("supply test done");
  endtask

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      $display("unexpected timeout: run did not finish");
      test_done;
    end
  end

  // main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    reset = 1'b1;
    mr_n = 1'b1;
    mr_fl = 1'b0;
    st_fl = 1'b0;
    uv = 1'b1;
    svc = 1'b0;
    period = 16'h0064;
    pulse = 16'h0007;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_power_wdog;
    t_strobe;
    t_manual;
    t_supply;
    test_done;
  end
endmodule
